/* core/gbc_pkg.sv */
/*
  Shared constants for the authenticated counter-mode block engine:
  widths, key size codes, round counts, block kinds and FSM states.
  Assumes every design file refers to it as gbc_pkg::name, never imported.
*/
package gbc_pkg;

  // Datapath widths
  localparam int BLK_W    = 128;             // Cipher block width
  localparam int WORD_W   = 32;              // Compact datapath word
  localparam int COLS     = 4;               // Columns per block
  localparam int RK_AW    = 4;               // Round key address width
  localparam int FIFO_DEP = 16;              // Result queue depth
  localparam int CYC_W    = 6;               // Cycle counter width

  // Key size selector codes
  localparam logic [1:0] KSZ_128 = 2'h0;
  localparam logic [1:0] KSZ_192 = 2'h1;
  localparam logic [1:0] KSZ_256 = 2'h2;

  // Round counts per key size
  localparam logic [3:0] NR_128 = 4'hA;
  localparam logic [3:0] NR_192 = 4'hC;
  localparam logic [3:0] NR_256 = 4'hE;

  // Input block kinds
  localparam logic [1:0] KIND_AAD  = 2'h0;   // Additional data, hashed only
  localparam logic [1:0] KIND_DATA = 2'h1;   // Payload, ciphered and hashed
  localparam logic [1:0] KIND_LEN  = 2'h2;   // Length block, closes the tag

  // Low word of the first counter block, and the field reduction constant
  localparam logic [31:0]      CTR_INIT = 32'h0000_0001;
  localparam logic [BLK_W-1:0] GF_POLY  = {8'hE1, 120'h0};

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_CIPH = 5'h02,
    S_WAIT = 5'h04,
    S_EMIT = 5'h08,
    S_TAG  = 5'h10
  } gbc_state_type;

  // Round count from the key size selector; code 11 falls back to 10 rounds
  function automatic logic [3:0] nr_of(input logic [1:0] ksel);
    unique case (ksel)
      KSZ_192: return NR_192;
      KSZ_256: return NR_256;
      default: return NR_128;
    endcase
  endfunction : nr_of

  // Key memory address of a round: forward, or top down when decrypting
  function automatic logic [RK_AW-1:0] rk_of(input logic [3:0] rnd,
                                             input logic [3:0] nr,
                                             input logic       dec);
    return dec ? nr - rnd : rnd;
  endfunction : rk_of

endpackage : gbc_pkg

/* core/gbc_strm_if.sv */
/*
  Valid/ready stream carrier between the engine and its result queue.
  Assumes both ends share one clock; data is held while valid waits.
*/
`timescale 1ns/10ps
`default_nettype none
interface gbc_strm_if #(parameter int W = 128) ();
  logic         valid;  // Source offers a word
  logic         ready;  // Sink can take it
  logic [W-1:0] data;   // Word on offer
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : gbc_strm_if
`default_nettype wire

/* core/gbc_fifo.sv */
/*
  Shift-register result queue: head always sits in entry 0, so the
  output word and valid come straight from flip-flops.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module gbc_fifo #(
  parameter int W     = 128,
  parameter int DEPTH = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  gbc_strm_if.snk           in_s,
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_r [DEPTH];  // Entry 0 is the head
  logic [CW-1:0] cnt_r;          // Words held
  logic [CW-1:0] cnt_nxt;
  logic          ready_r;        // Room for one more
  logic          push;
  logic          pop;

  assign push       = in_s.valid && ready_r;
  assign pop        = out_valid && out_ready;
  assign in_s.ready = ready_r;
  assign out_data   = mem_r[0];
  assign cnt_nxt    = cnt_r + CW'(push) - CW'(pop);

  // Storage: shift toward the head on a pop, write at the tail on a push
  always_ff @(posedge clock) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n) begin
        mem_r[i] <= '0;
      end else if (pop) begin
        if (push && i == int'(cnt_r) - 1) begin
          mem_r[i] <= in_s.data;
        end else if (i < DEPTH - 1) begin
          mem_r[i] <= mem_r[i+1];
        end
      end else if (push && i == int'(cnt_r)) begin
        mem_r[i] <= in_s.data;
      end
    end
  end

  // Fill level and the flags derived from it, both registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r     <= '0;
      out_valid <= 1'b0;
      ready_r   <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      out_valid <= cnt_nxt != '0;
      ready_r   <= cnt_nxt != CW'(DEPTH);
    end
  end
endmodule : gbc_fifo
`default_nettype wire

/* core/gbc_gfmul.sv */
/*
  Combinational multiply in the 128-bit Galois field with bit-reflected
  ordering, as used by the tag hash. Assumes the caller registers the product.
*/
`timescale 1ns/10ps
`default_nettype none
module gbc_gfmul (
  input  wire logic [127:0] a,
  input  wire logic [127:0] b,
  output var  logic [127:0] p
);
  logic [127:0] v;  // Running multiple of b

  // Shift-and-add over all 128 bits; deep but single-cycle by design
  always_comb begin
    p = '0;
    v = b;
    for (int i = 0; i < 128; i++) begin
      if (a[127-i]) begin
        p = p ^ v;
      end
      v = v[0] ? ((v >> 1) ^ gbc_pkg::GF_POLY) : (v >> 1);
    end
  end
endmodule : gbc_gfmul
`default_nettype wire

/* core/gbc_engine.sv */
/*
  Authenticated counter-mode block engine: round sequencer, counter,
  tag hash accumulator and a queue for result blocks.
  Assumes host logic on the same clock supplies vector, hash key and blocks,
  and a key expander or key memory answers rk_addr with rk_data in the
  same cycle (combinational read).
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Key size selector picks 10, 12, 14 rounds
// - 128-bit blocks in and out, three key sizes
// - First step mixes block with round key
// - Round: substitute, rotate rows, mix columns, key
// - Last round skips column mix, then output
// - Counter loads from host vector before data
// - Data combined with encrypted counter, both directions
// - Tag hashes additional data and ciphertext blocks
// - Encrypt round keys may come on the fly
// - Decrypt reads key memory in reverse order
// - Compact build: 32-bit path, 44/52/60 cycles
// - Fast build: 128-bit path, 11/13/15 cycles
module gbc_engine #(
  parameter bit FAST = 1'b1  // 1: full-block datapath, 0: one column a cycle
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         start,         // Begin a message, idle only
  input  wire logic [1:0]   key_size_sel,  // Key size code, taken at start
  input  wire logic         decrypt,       // Direction, taken at start
  input  wire logic [95:0]  iv,            // Vector, taken at start
  input  wire logic [127:0] hash_key,      // Hash subkey, taken at start
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [1:0]   in_kind,       // Additional, payload or length
  input  wire logic [127:0] in_data,
  output var  logic [3:0]   rk_addr,       // Round key address
  input  wire logic [127:0] rk_data,       // Round key, same cycle
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [127:0] out_data,
  output var  logic         tag_valid,     // One-cycle tag strobe
  output var  logic [127:0] tag,
  output var  logic         busy
);
  localparam int BW = gbc_pkg::BLK_W;
  localparam int WW = gbc_pkg::WORD_W;

  gbc_pkg::gbc_state_type st_r;   // Sequencer state
  gbc_pkg::gbc_state_type st_nxt;

  logic [3:0]    nr_r;            // Rounds for this message
  logic          dec_r;           // Decrypting
  logic          mask_r;          // Current cipher run makes the tag mask
  logic [BW-1:0] hkey_r;          // Hash subkey
  logic [BW-1:0] ctr_r;           // Counter block
  logic [BW-1:0] state_r;         // Cipher state storage
  logic [3:0]    round_r;         // Round in progress, 0 is the key mix
  logic [1:0]    col_r;           // Column in progress, compact only
  logic [BW-1:0] blk_r;           // Payload block being processed
  logic [BW-1:0] ek0_r;           // Encrypted first counter, tag mask
  logic [BW-1:0] acc_r;           // Hash accumulator
  logic [3:0]    rk_addr_r;
  logic          in_ready_r;
  logic          tag_valid_r;
  logic [BW-1:0] tag_r;
  logic          busy_r;

  logic [BW-1:0] step_nxt;        // State after the current step
  logic          step_last;       // Current cycle completes a round
  logic          take;            // Input block accepted
  logic          ciph_done;       // Final round completes this cycle
  logic [BW-1:0] res;             // Counter-mode result
  logic [BW-1:0] gf_x;            // Hash multiplier operand
  logic [BW-1:0] gf_p;            // Hash product
  logic [BW-1:0] ctr_inc;         // Counter with low word bumped

  gbc_strm_if #(.W(BW)) res_s ();

  assign take      = in_valid && in_ready_r;
  assign ciph_done = (st_r == gbc_pkg::S_CIPH) && step_last && (round_r == nr_r);
  assign ctr_inc   = {ctr_r[BW-1:WW], ctr_r[WW-1:0] + 32'h0000_0001};
  assign res       = blk_r ^ state_r;
  assign in_ready  = in_ready_r;
  assign rk_addr   = rk_addr_r;
  assign tag_valid = tag_valid_r;
  assign tag       = tag_r;
  assign busy      = busy_r;

  // Byte multiply in the cipher field
  function automatic logic [7:0] gmul8(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
    end
    return p;
  endfunction : gmul8

  // Substitution box computed, not tabled: inverse as x^254, then affine map
  function automatic logic [7:0] sbox(input logic [7:0] b);
    logic [7:0] sq;
    logic [7:0] inv;
    sq  = b;
    inv = 8'h01;
    for (int i = 0; i < 7; i++) begin
      sq  = gmul8(sq, sq);
      inv = gmul8(inv, sq);
    end
    return inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]}
               ^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]} ^ 8'h63;
  endfunction : sbox

  // One output column of a round; shared by both datapath widths
  function automatic logic [31:0] col_out(input logic [127:0] s, input int c,
                                          input logic [31:0] k,
                                          input logic first, input logic last);
    logic [7:0] b [4];
    logic [7:0] m [4];
    for (int r = 0; r < 4; r++) begin
      b[r] = sbox(s[(127 - 32*((c + r) % 4) - 8*r) -: 8]);
    end
    for (int r = 0; r < 4; r++) begin
      m[r] = gmul8(b[r], 8'h02) ^ gmul8(b[(r+1)%4], 8'h03)
           ^ b[(r+2)%4] ^ b[(r+3)%4];
    end
    if (first) begin
      return s[(127 - 32*c) -: 32] ^ k;
    end else if (last) begin
      return {b[0], b[1], b[2], b[3]} ^ k;
    end
    return {m[0], m[1], m[2], m[3]} ^ k;
  endfunction : col_out

  // Datapath width is a build choice; both share the column function
  if (FAST) begin : g_fast
    // Whole block per cycle: key mix plus one cycle per round
    always_comb begin
      for (int c = 0; c < gbc_pkg::COLS; c++) begin
        step_nxt[(127 - 32*c) -: 32] = col_out(state_r, c,
          rk_data[(127 - 32*c) -: 32], round_r == 4'h0, round_r == nr_r);
      end
    end
    assign step_last = 1'b1;
  end else begin : g_compact
    logic [95:0] shadow_r;  // Columns already done this round
    logic [31:0] col_w;
    // One column per cycle; the state is read whole until the round ends
    assign col_w = col_out(state_r, int'(col_r),
      rk_data[(127 - 32*int'(col_r)) -: 32], round_r == 4'h0,
      round_r == nr_r);
    assign step_nxt  = {shadow_r, col_w};
    assign step_last = col_r == 2'h3;
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        shadow_r <= '0;
      end else if (st_r == gbc_pkg::S_CIPH) begin
        shadow_r <= {shadow_r[63:0], col_w};
      end
    end
  end

  // Hash multiplier shared by additional data, payload and length blocks
  assign gf_x = acc_r ^ ((st_r == gbc_pkg::S_EMIT) ? (dec_r ? blk_r : res) : in_data);

  gbc_gfmul u_gf (
    .a (gf_x),
    .b (hkey_r),
    .p (gf_p)
  );

  // Result queue; a full queue holds the engine in the emit state
  assign res_s.valid = st_r == gbc_pkg::S_EMIT;
  assign res_s.data  = res;

  gbc_fifo #(.W(BW), .DEPTH(gbc_pkg::FIFO_DEP)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_s      (res_s),
    .out_valid (out_valid),
    .out_data  (out_data),
    .out_ready (out_ready)
  );

  // Next state of the sequencer
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      gbc_pkg::S_IDLE: begin
        if (start) begin
          st_nxt = gbc_pkg::S_CIPH;
        end
      end
      gbc_pkg::S_CIPH: begin
        if (ciph_done) begin
          st_nxt = mask_r ? gbc_pkg::S_WAIT : gbc_pkg::S_EMIT;
        end
      end
      gbc_pkg::S_WAIT: begin
        if (take && in_kind == gbc_pkg::KIND_DATA) begin
          st_nxt = gbc_pkg::S_CIPH;
        end else if (take && in_kind == gbc_pkg::KIND_LEN) begin
          st_nxt = gbc_pkg::S_TAG;
        end
      end
      gbc_pkg::S_EMIT: begin
        if (res_s.ready) begin
          st_nxt = gbc_pkg::S_WAIT;
        end
      end
      gbc_pkg::S_TAG: begin
        st_nxt = gbc_pkg::S_IDLE;
      end
    endcase
  end

  // Sequencer register and the flags that follow it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r       <= gbc_pkg::S_IDLE;
      in_ready_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      in_ready_r <= st_nxt == gbc_pkg::S_WAIT;
      busy_r     <= st_nxt != gbc_pkg::S_IDLE;
    end
  end

  // Message settings, captured once at start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nr_r   <= gbc_pkg::NR_128;
      dec_r  <= 1'b0;
      hkey_r <= '0;
    end else if (st_r == gbc_pkg::S_IDLE && start) begin
      nr_r   <= gbc_pkg::nr_of(key_size_sel);
      dec_r  <= decrypt;
      hkey_r <= hash_key;
    end
  end

  // Counter: seeded from the vector, bumped for each payload block
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctr_r <= '0;
    end else if (st_r == gbc_pkg::S_IDLE && start) begin
      ctr_r <= {iv, gbc_pkg::CTR_INIT};
    end else if (take && in_kind == gbc_pkg::KIND_DATA) begin
      ctr_r <= ctr_inc;
    end
  end

  // Round loop; a run starts from the counter, never from host data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r   <= '0;
      round_r   <= 4'h0;
      col_r     <= 2'h0;
      rk_addr_r <= 4'h0;
    end else if (st_r == gbc_pkg::S_IDLE && start) begin
      state_r   <= {iv, gbc_pkg::CTR_INIT};
      round_r   <= 4'h0;
      col_r     <= 2'h0;
      rk_addr_r <= gbc_pkg::rk_of(4'h0, gbc_pkg::nr_of(key_size_sel), decrypt);
    end else if (take && in_kind == gbc_pkg::KIND_DATA) begin
      state_r   <= ctr_inc;
      round_r   <= 4'h0;
      col_r     <= 2'h0;
      rk_addr_r <= gbc_pkg::rk_of(4'h0, nr_r, dec_r);
    end else if (st_r == gbc_pkg::S_CIPH) begin
      col_r <= FAST ? 2'h0 : col_r + 2'h1;
      if (step_last) begin
        // Round keys are consumed as addressed, so an on-the-fly expander
        // may follow rk_addr for encryption
        state_r   <= step_nxt;
        round_r   <= round_r + 4'h1;
        rk_addr_r <= gbc_pkg::rk_of(round_r + 4'h1, nr_r, dec_r);
      end
    end
  end

  // Payload block and tag mask
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blk_r  <= '0;
      ek0_r  <= '0;
      mask_r <= 1'b0;
    end else begin
      if (take && in_kind == gbc_pkg::KIND_DATA) begin
        blk_r <= in_data;
      end
      if (st_r == gbc_pkg::S_IDLE && start) begin
        mask_r <= 1'b1;
      end else if (ciph_done) begin
        mask_r <= 1'b0;
      end
      if (ciph_done && mask_r) begin
        ek0_r <= step_nxt;
      end
    end
  end

  // Hash accumulator: additional data and length straight in, ciphertext on emit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else if (st_r == gbc_pkg::S_IDLE && start) begin
      acc_r <= '0;
    end else if (take && in_kind != gbc_pkg::KIND_DATA) begin
      acc_r <= gf_p;
    end else if (st_r == gbc_pkg::S_EMIT && res_s.ready) begin
      acc_r <= gf_p;
    end
  end

  // Tag is released whole; comparing it is left to the host
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tag_r       <= '0;
      tag_valid_r <= 1'b0;
    end else begin
      tag_valid_r <= st_r == gbc_pkg::S_TAG;
      if (st_r == gbc_pkg::S_TAG) begin
        tag_r <= acc_r ^ ek0_r;
      end
    end
  end

  // Checks: cycle count of each cipher run
  logic [gbc_pkg::CYC_W-1:0] cyc_r;
  always_ff @(posedge clock) begin
    if (!rst_n || st_r != gbc_pkg::S_CIPH) begin
      cyc_r <= '0;
    end else begin
      cyc_r <= cyc_r + 6'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    st_r == gbc_pkg::S_IDLE && start;
  endsequence
  sequence s_take_data;
    take && in_kind == gbc_pkg::KIND_DATA;
  endsequence

  rounds_sel_a: assert property (s_start ##0 key_size_sel == 2'h1 |=> nr_r == 4'hC)
    else $error("round count not 12 for selector 01");
  init_mix_a: assert property (FAST && st_r == gbc_pkg::S_CIPH && round_r == 4'h0
    |=> state_r == $past(state_r ^ rk_data))
    else $error("first step is not block xor key");
  last_round_a: assert property (ciph_done |=> st_r != gbc_pkg::S_CIPH
    && round_r == nr_r + 4'h1)
    else $error("cipher did not stop after last round");
  ctr_load_a: assert property (s_start |=> ctr_r == {$past(iv), 32'h0000_0001}
    && state_r == ctr_r && st_r == gbc_pkg::S_CIPH)
    else $error("counter not seeded from vector");
  data_run_a: assert property (s_take_data |=> st_r == gbc_pkg::S_CIPH
    && blk_r == $past(in_data) && state_r == $past(ctr_inc))
    else $error("payload block did not start a counter run");
  tag_out_a: assert property (st_r == gbc_pkg::S_TAG |=> tag_valid_r
    && tag_r == $past(acc_r ^ ek0_r) ##1 !tag_valid_r)
    else $error("tag not mask xor hash");
  rk_reverse_a: assert property (st_r == gbc_pkg::S_CIPH && dec_r && step_last
    |=> rk_addr_r == $past(rk_addr_r) - 4'h1)
    else $error("decrypt key address not descending");
  fast_time_a: assert property (FAST && ciph_done |-> cyc_r + 6'h01
    == {2'h0, nr_r} + 6'h01)
    else $error("fast block time wrong");
  compact_time_a: assert property (!FAST && ciph_done |-> cyc_r + 6'h01
    == {nr_r, 2'h0} + 6'h04)
    else $error("compact block time wrong");
  reset_a: assert property (disable iff (1'b0) !rst_n |=> st_r == gbc_pkg::S_IDLE
    && !busy_r && !in_ready_r && !tag_valid_r)
    else $error("reset did not return to idle");

endmodule : gbc_engine
`default_nettype wire

/* dv/gbc_kmem.sv */
/*
  Key memory partner: answers a round key address with its key in the
  same cycle. Assumes an all-zero 128-bit cipher key, expanded ahead.
*/
`timescale 1ns/10ps
`default_nettype none
module gbc_kmem (
  input  wire logic [3:0]   rk_addr,
  input  wire logic         dec,
  input  wire logic [3:0]   nr,
  output var  logic [127:0] rk_data
);
  logic [3:0] rnd;  // Round whose key sits at this address

  // Decrypt layout keeps round r at address nr-r
  assign rnd = dec ? nr - rk_addr : rk_addr;

  // Combinational read, so keys can be consumed as they are produced
  always_comb begin
    case (rnd)
      4'h0:    rk_data = 128'h0;
      4'h1:    rk_data = {4{32'h62636363}};
      4'h2:    rk_data = {2{64'h9B9898C9F9FBFBAA}};
      4'h3:    rk_data = 128'h90973450696CCFFAF2F457330B0FAC99;
      4'h4:    rk_data = 128'hEE06DA7B876A1581759E42B27E91EE2B;
      4'h5:    rk_data = 128'h7F2E2B88F8443E098DDA7CBBF34B9290;
      4'h6:    rk_data = 128'hEC614B851425758C99FF09376AB49BA7;
      4'h7:    rk_data = 128'h217517873550620BACAF6B3CC61BF09B;
      4'h8:    rk_data = 128'h0EF903333BA9613897060A04511DFA9F;
      4'h9:    rk_data = 128'hB1D4D8E28A7DB9DA1D7BB3DE4C664941;
      4'hA:    rk_data = 128'hB4EF5BCB3E92E21123E951CF6F8F188E;
      // Longer keys only get junk: those runs are checked for timing
      default: rk_data = {32{~rnd}};
    endcase
  end
endmodule : gbc_kmem
`default_nettype wire

/* dv/tb.sv */
/*
  Self-checking bench for the engine: known-answer messages, latencies,
  round key order, queue fill and drain, resets.
  Assumes gbc_kmem on the key port and an all-zero key and vector.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  // Known answers for zero key, zero vector
  localparam logic [127:0] H0 = 128'h66E94BD4EF8A2C3B884CFA59CA342B2E;  // Hash subkey
  localparam logic [127:0] C2 = 128'h0388DACE60B6A392F328C2B971B2FE78;  // Zero block out
  localparam logic [127:0] T2 = 128'hAB6E47D42CEC13BDF53A67B21257BDDF;  // Its tag
  localparam logic [127:0] T1 = 128'h58E2FCCEFA7E3061367F1D57A4E7455A;  // Empty message tag
  localparam logic [127:0] L2 = 128'h80;                                // One block length

  logic         clock, rst_n, start, decrypt, in_valid, in_ready;
  logic         out_valid, out_ready, tag_valid, busy;
  logic [1:0]   key_size_sel, in_kind;
  logic [3:0]   rk_addr, kmem_nr;
  logic [95:0]  iv;
  logic [127:0] hash_key, in_data, rk_data, out_data, tag;
  logic         start_c, in_valid_c, in_ready_c, out_valid_c;  // Compact build
  logic [3:0]   rk_addr_c;
  logic [127:0] rk_data_c, out_data_c, tag_c;
  int           mismatches, checks;

  gbc_engine #(.FAST(1'b1)) i_dut (
    .clock(clock), .rst_n(rst_n), .start(start), .key_size_sel(key_size_sel),
    .decrypt(decrypt), .iv(iv), .hash_key(hash_key), .in_valid(in_valid),
    .in_ready(in_ready), .in_kind(in_kind), .in_data(in_data), .rk_addr(rk_addr),
    .rk_data(rk_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .tag_valid(tag_valid), .tag(tag), .busy(busy));
  gbc_kmem i_kmem (.rk_addr(rk_addr), .dec(decrypt), .nr(kmem_nr), .rk_data(rk_data));
  gbc_engine #(.FAST(1'b0)) i_dut_c (
    .clock(clock), .rst_n(rst_n), .start(start_c), .key_size_sel(key_size_sel),
    .decrypt(decrypt), .iv(iv), .hash_key(hash_key), .in_valid(in_valid_c),
    .in_ready(in_ready_c), .in_kind(in_kind), .in_data(in_data), .rk_addr(rk_addr_c),
    .rk_data(rk_data_c), .out_valid(out_valid_c), .out_ready(out_ready),
    .out_data(out_data_c), .tag_valid(), .tag(tag_c), .busy());
  gbc_kmem i_kmem_c (.rk_addr(rk_addr_c), .dec(decrypt), .nr(kmem_nr), .rk_data(rk_data_c));

  // 200 MHz clock
  always #2.5 clock = ~clock;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Wait at falling edges for in_ready, out_valid or tag_valid, bounded
  task automatic wt(input int sel, output int n);
    n = 0;
    while (((sel == 0) ? in_ready : (sel == 1) ? out_valid : tag_valid) !== 1'b1
           && n < 200) begin
      @(negedge clock);
      n++;
    end
  endtask : wt

  task automatic chk_idle(input string nm);
    check(nm, 0, {busy, in_ready, out_valid, tag_valid, rk_addr});
    check(nm, 0, {out_data, tag});
  endtask : chk_idle

  // Start a message; the mask run must read one key per cycle
  task automatic begin_msg(input logic [1:0] ks, input logic dc);
    int nr;
    nr = (ks == 2'h1) ? 12 : (ks == 2'h2) ? 14 : 10;
    @(negedge clock);
    key_size_sel = ks;
    decrypt      = dc;
    kmem_nr      = 4'(nr);
    start        = 1'b1;
    @(negedge clock);
    start = 1'b0;
    for (int k = 1; k <= nr + 1; k++) begin
      check("in_ready early", 0, in_ready);
      check("rk_addr", dc ? 128'(nr - k + 1) : 128'(k - 1), rk_addr);
      @(negedge clock);
    end
    check("in_ready", 1, in_ready);
  endtask : begin_msg

  // Offer one block; in_ready is high at entry, taken at the next edge
  task automatic send(input logic [1:0] kd, input logic [127:0] d);
    in_valid = 1'b1;
    in_kind  = kd;
    in_data  = d;
    @(negedge clock);
    in_valid = 1'b0;
  endtask : send

  task automatic pop(input logic [127:0] e);
    logic [127:0] g;
    out_ready = 1'b1;
    g         = out_data;
    @(negedge clock);
    out_ready = 1'b0;
    check("out_data", e, g);
  endtask : pop

  // Length block closes the message; the tag strobe lasts one cycle
  task automatic close(input logic [127:0] len, input logic [127:0] et, input logic chk);
    int n;
    send(gbc_pkg::KIND_LEN, len);
    wt(2, n);
    check("tag delay", 1, n);
    if (chk) check("tag", et, tag);
    check("busy", 0, busy);
    @(negedge clock);
    check("tag strobe", 0, tag_valid);
  endtask : close

  task automatic t_midrst();
    @(negedge clock);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b0;
    @(negedge clock);
    rst_n = 1'b1;
    chk_idle("mid reset");
    $display("test midrst done");
  endtask : t_midrst

  // Payload one way, then the other; both tags cover the ciphertext
  task automatic t_data(input logic dc, input logic [127:0] d, input logic [127:0] e);
    int n;
    begin_msg(2'h0, dc);
    send(gbc_pkg::KIND_DATA, d);
    wt(1, n);
    check("out delay", 12, n);
    check("in_ready again", 1, in_ready);
    pop(e);
    close(L2, T2, 1'b1);
    $display("test data done");
  endtask : t_data

  // Compact build: four cycles a round, same answers as the fast one
  task automatic t_compact();
    int n;
    @(negedge clock);
    key_size_sel = 2'h0;
    start_c      = 1'b1;
    @(negedge clock);
    start_c = 1'b0;
    for (n = 0; n < 200 && in_ready_c !== 1'b1; n++) @(negedge clock);
    check("compact mask time", 44, n);
    in_valid_c = 1'b1;
    in_kind    = gbc_pkg::KIND_DATA;
    in_data    = 128'h0;
    @(negedge clock);
    in_valid_c = 1'b0;
    for (n = 0; n < 200 && out_valid_c !== 1'b1; n++) @(negedge clock);
    check("compact out delay", 45, n);
    check("compact out_data", C2, out_data_c);
    in_valid_c = 1'b1;
    in_kind    = gbc_pkg::KIND_LEN;
    in_data    = L2;
    @(negedge clock);
    in_valid_c = 1'b0;
    @(negedge clock);
    check("compact tag", T2, tag_c);
    $display("test compact done");
  endtask : t_compact

  // Queue of 16 plus one held block, then drained at full rate
  task automatic t_full();
    int n;
    int cnt;
    begin_msg(2'h0, 1'b0);
    cnt = 0;
    n   = 0;
    while (n < 200 && cnt < 20) begin
      send(gbc_pkg::KIND_DATA, 128'h0);
      cnt++;
      wt(0, n);
    end
    check("blocks taken", 17, cnt);
    cnt       = 0;
    out_ready = 1'b1;
    repeat (100) begin
      if (out_valid === 1'b1) cnt++;
      @(negedge clock);
    end
    out_ready = 1'b0;
    check("blocks drained", 17, cnt);
    check("in_ready drained", 1, in_ready);
    close(L2, 128'h0, 1'b0);
    $display("test full done");
  endtask : t_full

  initial begin
    clock = 1'b0;  rst_n = 1'b0;  start = 1'b0;  key_size_sel = 2'h0;
    decrypt = 1'b0;  iv = 96'h0;  hash_key = H0;  in_valid = 1'b0;
    in_kind = 2'h0;  in_data = 128'h0;  out_ready = 1'b0;  kmem_nr = 4'hA;
    mismatches = 0;  checks = 0;  start_c = 1'b0;  in_valid_c = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    chk_idle("reset");
    t_midrst();
    t_data(1'b0, 128'h0, C2);
    t_data(1'b1, C2, 128'h0);
    begin_msg(2'h0, 1'b0);
    close(128'h0, T1, 1'b1);
    $display("test empty done");
    // Codes 01, 10 and the fallback 11
    for (int ks = 1; ks < 4; ks++) begin
      begin_msg(2'(ks), 1'b0);
      close(128'h0, 128'h0, 1'b0);
    end
    $display("test keysize done");
    t_compact();
    t_full();
    finish_test();
  end

  // Watchdog: the whole sequence needs under a thousand cycles
  initial begin
    #50000;
    mismatches++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
